// file: hdl/dwc_pkg.sv
// Constants shared by both ends of the DMA write command link.
// Assumes one clock (mclk_i, 200 MHz) and a synchronous active-low reset.
// Operation
// - EBh takes one sector into buffer
// - Buffer write and read share 512 bytes
// - CAh/CBh 8-bit count, 00h is 256
// - Start at given LBA, consecutive sectors
// - Data moves as 16-bit words
// - Host arms DMA before writing opcode
// - Words move only while request asserted
// - One interrupt after data phase ends
// - Uncorrectable error stops at failing sector
// - Error returns first failing sector LBA
// - Status bits 5 fault, 1 sense, 0 error
// - 3Dh commits media before ending status
// - 48-bit count 0000h means 65,536
// - Host sets select bit 6 for 3Dh
// - 35h is 48-bit DMA write
// - Count current 7:0, previous 15:8
// - LBA bytes from current and previous
// - High-byte select picks upper LBA bytes
package dwc_pkg;
  // Opcodes
  localparam logic [7:0] OP_BUF_WR = 8'heb;
  localparam logic [7:0] OP_WR28_A = 8'hca;
  localparam logic [7:0] OP_WR28_B = 8'hcb;
  localparam logic [7:0] OP_WR48 = 8'h35;
  localparam logic [7:0] OP_WR48_FUA = 8'h3d;
  // Geometry
  localparam int SECTOR_BYTES = 512;
  localparam int WORD_BITS = 16;
  localparam int WORDS_PER_SECTOR = SECTOR_BYTES * 8 / WORD_BITS;
  localparam logic [16:0] COUNT28_ZERO = 17'h00100;
  localparam logic [16:0] COUNT48_ZERO = 17'h10000;
  // Status, error and select fields
  localparam int ST_BUSY = 7;
  localparam int ST_READY = 6;
  localparam int ST_FAULT = 5;
  localparam int ST_REQ = 3;
  localparam int ST_SENSE = 1;
  localparam int ST_ERR = 0;
  localparam int ER_ID = 4;
  localparam int ER_ABORT = 2;
  localparam int SEL_LBA = 6;
  localparam logic [7:0] STATUS_RESET = 8'h40;
  // Media commit time per sector, in cycles
  localparam int COMMIT_CYCLES = 4;
  // Register selects for the taskfile port
  localparam logic [2:0] RS_SECNUM = 3'h3;
  localparam logic [2:0] RS_CYLLO = 3'h4;
  localparam logic [2:0] RS_CYLHI = 3'h5;
  localparam logic [2:0] RS_COUNT = 3'h2;
  localparam logic [2:0] RS_SELECT = 3'h6;
  localparam logic [2:0] RS_CMD = 3'h7;
  localparam logic [2:0] RS_ERROR = 3'h1;
  localparam logic [2:0] RS_STATUS = 3'h0;
endpackage

// file: hdl/dwc_link_if.sv
// Taskfile and slave-DMA link between host end and device end.
// Assumes both ends run on the same clock; no tristate here.
`timescale 1ns/10ps
interface dwc_link_if;
  logic tf_wr;
  logic tf_rd;
  logic [2:0] tf_sel;
  logic tf_hob;
  logic [7:0] tf_wdata;
  logic [7:0] tf_rdata;
  logic dma_req;
  logic dma_ack;
  logic [15:0] dma_data;
  logic irq;
  modport dev (input tf_wr, tf_rd, tf_sel, tf_hob, tf_wdata, dma_ack, dma_data,
               output tf_rdata, dma_req, irq);
  modport host (output tf_wr, tf_rd, tf_sel, tf_hob, tf_wdata, dma_ack, dma_data,
                input tf_rdata, dma_req, irq);
endinterface // dwc_link_if

// file: hdl/dwc_byte_pair.sv
// Two-deep taskfile byte: current and previous written value.
// Assumes write strobe is on the same clock.
`timescale 1ns/10ps
module dwc_byte_pair (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Write side
  input wire logic wr_i,
  input wire logic [7:0] data_i,
  // Stored bytes
  output logic [7:0] cur_o,
  output logic [7:0] prev_o
);
  // Each write pushes the current byte into the previous slot
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cur_o <= 8'h00;
      prev_o <= 8'h00;
    end else if (wr_i) begin
      prev_o <= cur_o;
      cur_o <= data_i;
    end
  end
endmodule // dwc_byte_pair

// file: hdl/dwc_device.sv
// Device end: decodes DMA write opcodes, paces words, reports status.
// Assumes host keeps request/ack protocol and one clock domain.
`timescale 1ns/10ps
module dwc_device #(
  parameter int LBA_FAIL_DEFAULT = 0
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Link
  dwc_link_if.dev link,
  // Media side
  input wire logic media_fail_i,
  input wire logic [47:0] fail_lba_i,
  input wire logic write_cache_i,
  output logic media_we_o,
  output logic [47:0] media_lba_o,
  output logic [15:0] media_data_o,
  output logic [8:0] buf_addr_o,
  output logic busy_o
);
  typedef enum {S_IDLE, S_XFER, S_COMMIT, S_DONE} dwc_state_t;
  dwc_state_t state;
  logic [7:0] cmd;
  logic [7:0] select;
  logic [7:0] err_reg;
  logic [7:0] stat_reg;
  logic [47:0] lba_cur;
  logic [47:0] lba_err;
  logic [16:0] sectors_left;
  logic [7:0] word_idx;
  logic [7:0] commit_cnt;
  logic [7:0] cnt_c, cnt_p, sn_c, sn_p, cl_c, cl_p, ch_c, ch_p;
  logic [15:0] sector_buf [0:dwc_pkg::WORDS_PER_SECTOR-1];
  logic cmd_wr;
  logic is_buf, is_48, is_fua, known;
  logic [16:0] count28, count48;
  logic word_take;

  // Taskfile byte pairs
  dwc_byte_pair u_cnt (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .wr_i(link.tf_wr && link.tf_sel == dwc_pkg::RS_COUNT), .data_i(link.tf_wdata),
    .cur_o(cnt_c), .prev_o(cnt_p));
  dwc_byte_pair u_sn (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .wr_i(link.tf_wr && link.tf_sel == dwc_pkg::RS_SECNUM), .data_i(link.tf_wdata),
    .cur_o(sn_c), .prev_o(sn_p));
  dwc_byte_pair u_cl (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .wr_i(link.tf_wr && link.tf_sel == dwc_pkg::RS_CYLLO), .data_i(link.tf_wdata),
    .cur_o(cl_c), .prev_o(cl_p));
  dwc_byte_pair u_ch (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .wr_i(link.tf_wr && link.tf_sel == dwc_pkg::RS_CYLHI), .data_i(link.tf_wdata),
    .cur_o(ch_c), .prev_o(ch_p));

  // Opcode decode
  assign cmd_wr = link.tf_wr && link.tf_sel == dwc_pkg::RS_CMD && state == S_IDLE;
  assign is_buf = link.tf_wdata == dwc_pkg::OP_BUF_WR;
  assign is_48 = link.tf_wdata == dwc_pkg::OP_WR48 ||
                 link.tf_wdata == dwc_pkg::OP_WR48_FUA;
  assign is_fua = link.tf_wdata == dwc_pkg::OP_WR48_FUA;
  assign known = is_buf || is_48 || link.tf_wdata == dwc_pkg::OP_WR28_A ||
                 link.tf_wdata == dwc_pkg::OP_WR28_B;
  // Zero counts widen to the full range
  assign count28 = (cnt_c == 8'h00) ? dwc_pkg::COUNT28_ZERO : {9'h000, cnt_c};
  assign count48 = ({cnt_p, cnt_c} == 16'h0000) ? dwc_pkg::COUNT48_ZERO
                   : {1'b0, cnt_p, cnt_c};
  // A word moves when both request and ack are high
  assign word_take = state == S_XFER && link.dma_req && link.dma_ack;

  // Device select register
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) select <= 8'h00;
    else if (link.tf_wr && link.tf_sel == dwc_pkg::RS_SELECT) select <= link.tf_wdata;
  end

  // Command sequencer
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state <= S_IDLE;
      cmd <= 8'h00;
      lba_cur <= 48'h0;
      sectors_left <= 17'h0;
      word_idx <= 8'h00;
      commit_cnt <= 8'h00;
      err_reg <= 8'h00;
      stat_reg <= dwc_pkg::STATUS_RESET;
      lba_err <= 48'h0;
      link.irq <= 1'b0;
      link.dma_req <= 1'b0;
      media_we_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      media_we_o <= 1'b0;
      unique case (state)
        S_IDLE: begin
          if (cmd_wr) begin
            cmd <= link.tf_wdata;
            link.irq <= 1'b0;
            err_reg <= 8'h00;
            word_idx <= 8'h00;
            busy_o <= 1'b1;
            if (!known) begin
              err_reg[dwc_pkg::ER_ABORT] <= 1'b1;
              stat_reg <= 8'h41;
              state <= S_DONE;
            end else begin
              stat_reg <= 8'h88;
              link.dma_req <= 1'b1;
              state <= S_XFER;
              // buffer write ignores count and address
              sectors_left <= is_buf ? 17'h1 : (is_48 ? count48 : count28);
              lba_cur <= is_48 ? {ch_p, cl_p, sn_p, ch_c, cl_c, sn_c}
                         : {20'h0, select[3:0], ch_c, cl_c, sn_c};
            end
          end
        end
        S_XFER: begin
          if (word_take) begin
            word_idx <= word_idx + 8'h01;
            if (word_idx == 8'(dwc_pkg::WORDS_PER_SECTOR - 1)) begin
              link.dma_req <= 1'b0;
              commit_cnt <= 8'h00;
              state <= S_COMMIT;
            end
          end
        end
        S_COMMIT: begin
          // Buffer writes never reach media; FUA always waits for commit
          if (cmd == dwc_pkg::OP_BUF_WR) begin
            state <= S_DONE;
            stat_reg <= 8'h50;
          end else if (media_fail_i) begin
            lba_err <= lba_cur;
            err_reg[dwc_pkg::ER_ID] <= 1'b1;
            stat_reg <= 8'h41;
            state <= S_DONE;
          end else if (commit_cnt == 8'(dwc_pkg::COMMIT_CYCLES - 1)) begin
            // Cache setting ignored: every media command waits out its commit
            media_we_o <= 1'b1;
            lba_cur <= lba_cur + 48'h1;
            sectors_left <= sectors_left - 17'h1;
            word_idx <= 8'h00;
            if (sectors_left == 17'h1) begin
              stat_reg <= 8'h50;
              state <= S_DONE;
            end else begin
              link.dma_req <= 1'b1;
              state <= S_XFER;
            end
          end else begin
            commit_cnt <= commit_cnt + 8'h01;
          end
        end
        S_DONE: begin
          link.irq <= 1'b1;
          busy_o <= 1'b0;
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Sector buffer shared by buffer write and read-back
  always_ff @(posedge mclk_i) begin
    if (word_take) sector_buf[word_idx] <= link.dma_data;
  end

  // Media view of the buffer
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      media_lba_o <= 48'h0;
      media_data_o <= 16'h0000;
      buf_addr_o <= 9'h000;
    end else begin
      media_lba_o <= lba_cur;
      media_data_o <= sector_buf[word_idx];
      buf_addr_o <= {word_idx, 1'b0};
    end
  end

  // Taskfile read port; high-byte select picks upper address bytes
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) link.tf_rdata <= 8'h00;
    else if (link.tf_rd) begin
      unique case (link.tf_sel)
        dwc_pkg::RS_STATUS: link.tf_rdata <= stat_reg;
        dwc_pkg::RS_ERROR: link.tf_rdata <= err_reg;
        dwc_pkg::RS_SECNUM: link.tf_rdata <= link.tf_hob ? lba_err[31:24] : lba_err[7:0];
        dwc_pkg::RS_CYLLO: link.tf_rdata <= link.tf_hob ? lba_err[39:32] : lba_err[15:8];
        dwc_pkg::RS_CYLHI: link.tf_rdata <= link.tf_hob ? lba_err[47:40] : lba_err[23:16];
        dwc_pkg::RS_SELECT: link.tf_rdata <= select;
        default: link.tf_rdata <= 8'h00;
      endcase
    end
  end
endmodule // dwc_device

// file: hdl/dwc_host.sv
// Host end: writes taskfile, arms DMA, feeds words while request is high.
// Assumes one clock and a user side that supplies words on demand.
`timescale 1ns/10ps
module dwc_host (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Link
  dwc_link_if.host link,
  // User command side
  input wire logic start_i,
  input wire logic [7:0] opcode_i,
  input wire logic [47:0] lba_i,
  input wire logic [15:0] count_i,
  input wire logic [15:0] word_i,
  input wire logic rd_i,
  input wire logic [2:0] rd_sel_i,
  input wire logic rd_hob_i,
  output logic word_take_o,
  output logic done_o,
  output logic busy_o
);
  typedef enum {H_IDLE, H_TF, H_RUN} dwc_hstate_t;
  dwc_hstate_t state;
  logic [3:0] step;
  logic armed;
  logic irq_q;

  // Taskfile write sequence then DMA run; arm precedes opcode
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state <= H_IDLE;
      step <= 4'h0;
      armed <= 1'b0;
      link.tf_wr <= 1'b0;
      link.tf_sel <= 3'h0;
      link.tf_wdata <= 8'h00;
      done_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      link.tf_wr <= 1'b0;
      done_o <= 1'b0;
      // Outside the taskfile burst the select follows the user's read choice
      if (state != H_TF) link.tf_sel <= rd_sel_i;
      unique case (state)
        H_IDLE: if (start_i) begin
          state <= H_TF;
          step <= 4'h0;
          busy_o <= 1'b1;
        end
        H_TF: begin
          link.tf_wr <= 1'b1;
          step <= step + 4'h1;
          unique case (step)
            4'h0: begin link.tf_sel <= dwc_pkg::RS_COUNT; link.tf_wdata <= count_i[15:8]; end
            4'h1: begin link.tf_sel <= dwc_pkg::RS_COUNT; link.tf_wdata <= count_i[7:0]; end
            4'h2: begin link.tf_sel <= dwc_pkg::RS_SECNUM; link.tf_wdata <= lba_i[31:24]; end
            4'h3: begin link.tf_sel <= dwc_pkg::RS_SECNUM; link.tf_wdata <= lba_i[7:0]; end
            4'h4: begin link.tf_sel <= dwc_pkg::RS_CYLLO; link.tf_wdata <= lba_i[39:32]; end
            4'h5: begin link.tf_sel <= dwc_pkg::RS_CYLLO; link.tf_wdata <= lba_i[15:8]; end
            4'h6: begin link.tf_sel <= dwc_pkg::RS_CYLHI; link.tf_wdata <= lba_i[47:40]; end
            4'h7: begin link.tf_sel <= dwc_pkg::RS_CYLHI; link.tf_wdata <= lba_i[23:16]; end
            4'h8: begin
              link.tf_sel <= dwc_pkg::RS_SELECT;
              link.tf_wdata <= {1'b0, 1'b1, 2'b00, lba_i[27:24]};
              armed <= 1'b1;
            end
            default: begin
              link.tf_sel <= dwc_pkg::RS_CMD;
              link.tf_wdata <= opcode_i;
              state <= H_RUN;
            end
          endcase
        end
        H_RUN: if (link.irq && !irq_q && !link.dma_req) begin
          armed <= 1'b0;
          done_o <= 1'b1;
          busy_o <= 1'b0;
          state <= H_IDLE;
        end
      endcase
    end
  end

  // Interrupt level one cycle back; the level left from the last command is no ending
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) irq_q <= 1'b0;
    else irq_q <= link.irq;
  end

  // Ack only while armed and request seen; one word each cycle
  assign link.dma_ack = armed && link.dma_req;
  assign link.dma_data = word_i;
  assign word_take_o = armed && link.dma_req;

  // Register reads forwarded from user
  assign link.tf_rd = rd_i && state != H_TF;
  assign link.tf_hob = rd_hob_i;
endmodule // dwc_host

// file: testbench/dwc_link_asserts.sv
// Checker on the taskfile and DMA signals between host and device ends.
// Assumes one clock, synchronous active-low reset, signals given plainly.
`timescale 1ns/10ps
module dwc_link_asserts (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Link signals
  input wire logic tf_wr,
  input wire logic tf_rd,
  input wire logic [2:0] tf_sel,
  input wire logic [7:0] tf_wdata,
  input wire logic [7:0] tf_rdata,
  input wire logic dma_req,
  input wire logic dma_ack,
  input wire logic irq
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  logic [8:0] wcnt;
  logic [7:0] sel_last;
  wire cmd_wr = tf_wr && tf_sel == dwc_pkg::RS_CMD;
  wire op_ok = tf_wdata inside {dwc_pkg::OP_BUF_WR, dwc_pkg::OP_WR28_A,
    dwc_pkg::OP_WR28_B, dwc_pkg::OP_WR48, dwc_pkg::OP_WR48_FUA};
  // Words in one request burst; cleared while request is low
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || !dma_req) wcnt <= 9'h000;
    else if (dma_ack) wcnt <= wcnt + 9'h001;
  end
  // Last select byte, so the opcode write can be judged against it
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) sel_last <= 8'h00;
    else if (tf_wr && tf_sel == dwc_pkg::RS_SELECT) sel_last <= tf_wdata;
  end
  a_ack_needs_req: assert property (dma_ack |-> dma_req)
    else $error("word moved without request");
  a_cmd_starts_req: assert property (cmd_wr && op_ok && !dma_req |=> dma_req)
    else $error("no request after write opcode");
  a_bad_op_abort: assert property (cmd_wr && !op_ok |-> ##2 irq && !dma_req)
    else $error("unknown opcode not aborted in time");
  a_irq_after_data: assert property ($rose(irq) |-> !dma_req && !$past(dma_req))
    else $error("interrupt during data phase");
  a_irq_level_holds: assert property (irq && !cmd_wr |=> irq)
    else $error("interrupt dropped before next command");
  a_fua_select: assert property (cmd_wr && tf_wdata == dwc_pkg::OP_WR48_FUA |-> sel_last[6])
    else $error("select bit 6 clear on forced write");
  a_commit_gap: assert property ($fell(dma_req) |-> !dma_req [*4])
    else $error("request back before commit ended");
  a_sector_words: assert property ($fell(dma_req) |-> wcnt == dwc_pkg::WORDS_PER_SECTOR)
    else $error("sector burst not 256 words");
  a_status_code: assert property ($past(tf_rd) && $past(tf_sel) == dwc_pkg::RS_STATUS
    && irq |-> tf_rdata inside {8'h50, 8'h41})
    else $error("ending status code wrong");
  c_fua: cover property (cmd_wr && tf_wdata == dwc_pkg::OP_WR48_FUA);
  c_bad_op: cover property (cmd_wr && !op_ok);
  c_irq: cover property ($rose(irq));
endmodule // dwc_link_asserts

// file: testbench/dma_write_command_handler_tb.sv
// Bench joining host and device ends; a scoreboard checks each result.
// Assumes package, link interface and both ends are compiled first.
`timescale 1ns/10ps
module dma_write_command_handler_tb;
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic start_i = 1'b0;
  logic rd_i = 1'b0;
  logic media_fail_i = 1'b0;
  logic skip = 1'b0;
  logic rd_seen = 1'b0;
  logic rd_hob_i = 1'b0;
  logic [2:0] rd_sel_i = dwc_pkg::RS_STATUS;
  logic [15:0] first_w = 16'h0000;
  logic [7:0] opcode_i = 8'h00;
  logic [47:0] lba_i = 48'h0;
  logic [15:0] count_i = 16'h0000;
  logic [15:0] word_i = 16'h0000;
  wire word_take_o, done_o, hbusy, media_we_o, dbusy;
  wire [47:0] media_lba_o;
  wire [15:0] media_data_o;
  int error_cnt = 0;
  int checks = 0;
  int wcnt = 0;
  int seed = 32'hfee9;
  logic [47:0] lq[$];
  int wq[$];
  logic [7:0] sq[$];
  always #2.5 mclk_i = ~mclk_i;
  dwc_link_if link();
  dwc_host dwc_host_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(link.host),
    .start_i(start_i), .opcode_i(opcode_i), .lba_i(lba_i), .count_i(count_i),
    .word_i(word_i), .rd_i(rd_i), .rd_sel_i(rd_sel_i), .rd_hob_i(rd_hob_i),
    .word_take_o(word_take_o), .done_o(done_o), .busy_o(hbusy));
  dwc_device dwc_device_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(link.dev),
    .media_fail_i(media_fail_i), .fail_lba_i(48'h0), .write_cache_i(1'b1),
    .media_we_o(media_we_o), .media_lba_o(media_lba_o), .media_data_o(media_data_o),
    .buf_addr_o(), .busy_o(dbusy));
  dwc_link_asserts dwc_link_asserts_i (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .tf_wr(link.tf_wr), .tf_rd(link.tf_rd), .tf_sel(link.tf_sel),
    .tf_wdata(link.tf_wdata), .tf_rdata(link.tf_rdata), .dma_req(link.dma_req),
    .dma_ack(link.dma_ack), .irq(link.irq));
  task automatic cmp(input logic [47:0] got, input logic [47:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Fresh random data word every cycle, taken only when the host wants one
  always @(posedge mclk_i) word_i <= 16'($random(seed));
  // Scoreboard: oldest note compared as each result appears
  always @(posedge mclk_i) begin
    if (rst_n_i) begin
      if (word_take_o === 1'b1) begin
        if (wcnt % dwc_pkg::WORDS_PER_SECTOR == 0) first_w = word_i;
        wcnt++;
      end
      if (media_we_o === 1'b1 && !skip) cmp(media_lba_o, lq.pop_front());
      if (done_o === 1'b1) begin
        cmp(48'(wcnt), 48'(wq.pop_front()));
        cmp({32'h0, media_data_o}, {32'h0, first_w});
        cmp({46'h0, hbusy, dbusy}, 48'h0);
        wcnt = 0;
      end
      if (rd_seen) cmp({40'h0, link.tf_rdata}, {40'h0, sq.pop_front()});
      rd_seen <= link.tf_rd;
    end
  end
  // One register read; the select leads the strobe by a cycle
  task automatic rd_chk(input logic [2:0] sel, input logic hob, input logic [7:0] exp);
    sq.push_back(exp);
    @(posedge mclk_i);
    rd_sel_i <= sel;
    rd_hob_i <= hob;
    @(posedge mclk_i);
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
  endtask
  // One command: note results, start, wait bounded, read status
  task automatic run(input logic [7:0] op, input logic [47:0] lba, input logic [15:0] cnt,
                     input int nsec, input int nw, input logic [7:0] st, input logic f);
    int n;
    n = 0;
    for (int i = 0; i < nsec; i++) lq.push_back(lba + 48'(i));
    wq.push_back(nw);
    @(posedge mclk_i);
    start_i <= 1'b1;
    opcode_i <= op;
    lba_i <= lba;
    count_i <= cnt;
    media_fail_i <= f;
    skip <= f || nsec == 0;
    @(posedge mclk_i);
    start_i <= 1'b0;
    @(negedge mclk_i);
    while (done_o !== 1'b1 && n < 80000) begin
      @(negedge mclk_i);
      n++;
    end
    if (n >= 80000) begin
      error_cnt++;
      final_report;
    end
    rd_chk(dwc_pkg::RS_STATUS, 1'b0, st);
    $display("test op %h ended", op);
  endtask
  // Main sequence; LBA bits 20 to 46 random, bit 47 and low 20 bits cleared to keep clear of wrap-around
  initial begin
    logic [47:0] r, q;
    r = 48'({$random(seed), $random(seed)}) & 48'h7fff_fff0_0000;
    q = 48'({$random(seed), $random(seed)});
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    run(dwc_pkg::OP_BUF_WR, r, 16'h0007, 0, 256, 8'h50, 1'b0);
    run(dwc_pkg::OP_WR28_A, r & 48'h0ff_ffff, 16'h0002, 2, 512, 8'h50, 1'b0);
    run(dwc_pkg::OP_WR28_B, r & 48'h0f0_0000, 16'h0000, 256, 65536, 8'h50, 1'b0);
    run(dwc_pkg::OP_WR48, r, 16'h0003, 3, 768, 8'h50, 1'b0);
    run(dwc_pkg::OP_WR48_FUA, q, 16'h0102, 0, 256, 8'h41, 1'b1);
    // Failing address read back in both byte halves
    rd_chk(dwc_pkg::RS_ERROR, 1'b0, 8'(1 << dwc_pkg::ER_ID));
    rd_chk(dwc_pkg::RS_SECNUM, 1'b0, q[7:0]);
    rd_chk(dwc_pkg::RS_SECNUM, 1'b1, q[31:24]);
    rd_chk(dwc_pkg::RS_CYLLO, 1'b0, q[15:8]);
    rd_chk(dwc_pkg::RS_CYLLO, 1'b1, q[39:32]);
    rd_chk(dwc_pkg::RS_CYLHI, 1'b0, q[23:16]);
    rd_chk(dwc_pkg::RS_CYLHI, 1'b1, q[47:40]);
    run(8'h20, r, 16'h0001, 0, 0, 8'h41, 1'b0);
    rd_chk(dwc_pkg::RS_ERROR, 1'b0, 8'(1 << dwc_pkg::ER_ABORT));
    final_report;
  end
  // Watchdog well past the expected run length
  initial begin
    #500000;
    error_cnt++;
    final_report;
  end
endmodule // dma_write_command_handler_tb
